// ==== smcc_pkg.sv ====
// constants, field layout and types for the strap, mode and crossover loader
package smcc_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned STRAP_SETTLE_NS  = 100;
  localparam int unsigned STRAP_SETTLE_CYC =
    (STRAP_SETTLE_NS * CLK_MHZ + 999) / 1000;  // least time, rounded up
  localparam int unsigned MDIX_SLOT_US     = 62;
  localparam int unsigned MDIX_SLOT_CYC    = MDIX_SLOT_US * CLK_MHZ;
  localparam int unsigned BLINK_MS         = 100;
  localparam int unsigned BLINK_CYC        = BLINK_MS * 1000 * CLK_MHZ;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int unsigned AW         = 8;
  localparam logic [7:0]  OFS_STRAP  = 8'h00;  // latched straps, read only
  localparam logic [7:0]  OFS_CFG    = 8'h04;  // address, mode, soft reset
  localparam logic [7:0]  OFS_STATUS = 8'h08;  // crossover state, read only
  localparam logic [7:0]  OFS_PHYCTL = 8'h10;  // phy_control_register

  // phy_control_register fields
  localparam int unsigned PC_XDIS_BIT   = 6;
  localparam int unsigned PC_XFORCE_BIT = 5;
  // configuration register fields
  localparam int unsigned CFG_ADDR_LSB  = 0;
  localparam int unsigned CFG_MODE_LSB  = 4;
  localparam int unsigned CFG_SRST_BIT  = 31;
  // status register fields
  localparam int unsigned ST_DONE_BIT   = 0;
  localparam int unsigned ST_CROSS_BIT  = 1;
  localparam int unsigned ST_RESOLV_BIT = 2;
  localparam int unsigned ST_AN_BIT     = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // operating mode codes
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_RGMII_COPPER = 3'h0;
  localparam logic [2:0] MODE_RGMII_1000X  = 3'h1;
  localparam logic [2:0] MODE_RGMII_100FX  = 3'h2;
  localparam logic [2:0] MODE_RGMII_SGMII  = 3'h3;
  localparam logic [2:0] MODE_COPPER_1000X = 3'h4;
  localparam logic [2:0] MODE_TX_100FX     = 3'h5;
  localparam logic [2:0] MODE_SGMII_COPPER = 3'h6;
  localparam logic [2:0] MODE_BSCAN        = 3'h7;

  // strap defaults
  localparam logic [3:0] ADDR_RESET = 4'h0;
  localparam logic [2:0] MODE_RESET = 3'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [2:0] mode;
    logic       xdis;
    logic       xforce;
  } smcc_strap_s;

  localparam smcc_strap_s STRAP_RESET = '{ADDR_RESET, MODE_RESET,
                                          1'b0, 1'b0};

  typedef enum {X_WAIT, X_HUNT, X_LOCK, X_FORCED} smcc_xstate_e;

endpackage

// ==== smcc_top.sv ====
// strap capture, mode decode, indicator defaults and crossover control
// Operation
// - swap pairs A/B on crossover; also swap C/D at gigabit
// - finish crossover resolution before auto-negotiation pulses start
// - when disabled, force straight or crossed from strap or bit 5
// - at 10/100 crossover runs regardless of negotiation or forced speed
// - sample all strap pins at power-up and every hard reset
// - software reset reloads settings from captured straps, no resample
// - two lowest receive data pins four-level, others two-level
// - address bits 1:0 from data 0, 3:2 from data 1, default 00
// - three-bit operating mode from three straps, default 000
// - mode 000: link any speed, gigabit link, activity indicators
// - modes 001/010: fibre link, transmit activity, receive activity
// - mode 011: serial link, serial gigabit link, activity indicators
// - mode 100: copper link, blink on 100M/half, fibre link, activity
// - host may override every strap setting through management registers
`timescale 1ns/1ps
module smcc_top #(
  parameter int unsigned SLOT_CYC  = smcc_pkg::MDIX_SLOT_CYC,
  parameter int unsigned BLINK_CYC = smcc_pkg::BLINK_CYC
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [smcc_pkg::AW-1:0] awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [smcc_pkg::AW-1:0] araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  input  wire logic [1:0][2:0]         receive_data_pin_level,
  input  wire logic [2:0]              operating_mode_strap,
  input  wire logic                    crossover_disable_strap,
  input  wire logic                    crossover_force_strap,
  input  wire logic                    energy_detect,
  input  wire logic                    link_up_copper,
  input  wire logic                    copper_speed_1g,
  input  wire logic                    copper_full_duplex,
  input  wire logic                    link_up_fiber,
  input  wire logic                    link_up_serial,
  input  wire logic                    serial_speed_1g,
  input  wire logic                    tx_activity,
  input  wire logic                    rx_activity,
  output logic [3:0]                   mgmt_address,
  output logic [2:0]                   operating_mode_code,
  output logic                         swap_pairs_ab,
  output logic                         swap_pairs_cd,
  output logic                         an_start_enable,
  output logic [2:0]                   led_out
);

  // assertion clock and reset for the whole module
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ---------------------------------------------------------------
  // strap pin synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned PW = 11;
  logic [PW-1:0]         pin_s1_q;
  logic [PW-1:0]         pin_s2_q;
  logic [1:0][1:0]       lvl_bin;
  smcc_pkg::smcc_strap_s strap_q;
  smcc_pkg::smcc_strap_s sampled;
  logic [31:0]           settle_q;
  logic                  strap_done_q;
  logic                  capture;

  // two flops on every strap pin before any decode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= {receive_data_pin_level, operating_mode_strap,
                   crossover_disable_strap, crossover_force_strap};
      pin_s2_q <= pin_s1_q;
    end
  end

  // thermometer comparator outputs to two-bit level per four-level pin
  for (genvar i = 0; i < 2; i++) begin : g_lvl
    logic [2:0] t;
    assign t = pin_s2_q[5 + 3*i +: 3];
    assign lvl_bin[i] = t[2] ? 2'h3 : t[1] ? 2'h2 :
                        t[0] ? 2'h1 : 2'h0;
  end

  // address from both four-level pins, two-level pins used as is
  assign sampled = '{{lvl_bin[1], lvl_bin[0]},
                     pin_s2_q[4:2],
                     pin_s2_q[1], pin_s2_q[0]};

  // ---------------------------------------------------------------
  // strap capture after hard reset
  // ---------------------------------------------------------------
  assign capture = !strap_done_q &&
                   (settle_q == smcc_pkg::STRAP_SETTLE_CYC - 1);

  // settle window lets the synchroniser fill, then latch once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_q     <= '0;
      strap_done_q <= 1'b0;
      strap_q      <= smcc_pkg::STRAP_RESET;
    end else if (capture) begin
      strap_done_q <= 1'b1;
      strap_q      <= sampled;
    end else if (!strap_done_q) begin
      settle_q     <= settle_q + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // register bus slave
  // ---------------------------------------------------------------
  logic [smcc_pkg::AW-1:0] aw_addr_q;
  logic                    aw_full_q;
  logic [31:0]             w_data_q;
  logic [3:0]              w_strb_q;
  logic                    w_full_q;
  logic                    wr_go;
  logic                    wr_hit;
  logic                    soft_rst;
  logic [3:0]              addr_q;
  logic [2:0]              mode_q;
  logic                    xdis_q;
  logic                    xforce_q;
  logic [31:0]             rd_val;
  logic                    rd_hit;
  smcc_pkg::smcc_xstate_e  xstate_q;
  logic                    crossed_q;

  assign wr_go  = aw_full_q && w_full_q && !bvalid;
  assign wr_hit = aw_addr_q == smcc_pkg::OFS_CFG ||
                  aw_addr_q == smcc_pkg::OFS_PHYCTL ||
                  aw_addr_q == smcc_pkg::OFS_STRAP ||
                  aw_addr_q == smcc_pkg::OFS_STATUS;
  assign soft_rst = wr_go && aw_addr_q == smcc_pkg::OFS_CFG &&
                    w_strb_q[3] && w_data_q[smcc_pkg::CFG_SRST_BIT];

  // address and data channels held independently, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= smcc_pkg::RESP_OKAY;
    end else begin
      awready <= !aw_full_q && !(awvalid && awready) && !bvalid;
      wready  <= !w_full_q && !(wvalid && wready) && !bvalid;
      if (awvalid && awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= {awaddr[smcc_pkg::AW-1:2], 2'h0};
      end
      if (wvalid && wready) begin
        w_full_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_hit ? smcc_pkg::RESP_OKAY : smcc_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // working settings: strap load, soft reload, host override
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_q   <= smcc_pkg::ADDR_RESET;
      mode_q   <= smcc_pkg::MODE_RESET;
      xdis_q   <= 1'b0;
      xforce_q <= 1'b0;
    end else if (capture) begin
      {addr_q, mode_q, xdis_q, xforce_q} <= sampled;
    end else if (soft_rst) begin
      {addr_q, mode_q, xdis_q, xforce_q} <= strap_q;
    end else if (wr_go && w_strb_q[0]) begin
      if (aw_addr_q == smcc_pkg::OFS_CFG) begin
        addr_q <= w_data_q[smcc_pkg::CFG_ADDR_LSB +: 4];
        mode_q <= w_data_q[smcc_pkg::CFG_MODE_LSB +: 3];
      end else if (aw_addr_q == smcc_pkg::OFS_PHYCTL) begin
        xdis_q   <= w_data_q[smcc_pkg::PC_XDIS_BIT];
        xforce_q <= w_data_q[smcc_pkg::PC_XFORCE_BIT];
      end
    end
  end

  // read data selection
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    case ({araddr[smcc_pkg::AW-1:2], 2'h0})
      smcc_pkg::OFS_STRAP:  rd_val[8:0] = strap_q;
      smcc_pkg::OFS_CFG: begin
        rd_val[smcc_pkg::CFG_ADDR_LSB +: 4] = addr_q;
        rd_val[smcc_pkg::CFG_MODE_LSB +: 3] = mode_q;
      end
      smcc_pkg::OFS_STATUS: begin
        rd_val[smcc_pkg::ST_DONE_BIT]   = strap_done_q;
        rd_val[smcc_pkg::ST_CROSS_BIT]  = crossed_q;
        rd_val[smcc_pkg::ST_RESOLV_BIT] = xstate_q == smcc_pkg::X_LOCK ||
                                          xstate_q == smcc_pkg::X_FORCED;
        rd_val[smcc_pkg::ST_AN_BIT]     = an_start_enable;
      end
      smcc_pkg::OFS_PHYCTL: begin
        rd_val[smcc_pkg::PC_XDIS_BIT]   = xdis_q;
        rd_val[smcc_pkg::PC_XFORCE_BIT] = xforce_q;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel, one word answered the edge after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= smcc_pkg::RESP_OKAY;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_val;
        rresp  <= rd_hit ? smcc_pkg::RESP_OKAY : smcc_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // crossover resolution
  // ---------------------------------------------------------------
  logic [31:0] slot_q;
  logic        slot_end;

  assign slot_end = slot_q == SLOT_CYC - 1;

  // hunt alternates mapping per slot; negotiation state is not consulted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xstate_q  <= smcc_pkg::X_WAIT;
      crossed_q <= 1'b0;
      slot_q    <= '0;
    end else begin
      slot_q <= (slot_end || xstate_q != smcc_pkg::X_HUNT) ? '0 :
                slot_q + 32'h1;
      case (xstate_q)
        smcc_pkg::X_WAIT: begin
          if (strap_done_q) xstate_q <= smcc_pkg::X_HUNT;
        end
        smcc_pkg::X_HUNT: begin
          if (xdis_q) xstate_q <= smcc_pkg::X_FORCED;
          else if (energy_detect) xstate_q <= smcc_pkg::X_LOCK;
          else if (slot_end) crossed_q <= !crossed_q;
        end
        smcc_pkg::X_LOCK: begin
          if (xdis_q) xstate_q <= smcc_pkg::X_FORCED;
          else if (!energy_detect && !link_up_copper)
            xstate_q <= smcc_pkg::X_HUNT;
        end
        smcc_pkg::X_FORCED: begin
          crossed_q <= xforce_q;
          if (!xdis_q) xstate_q <= smcc_pkg::X_HUNT;
        end
        default: xstate_q <= smcc_pkg::X_WAIT;
      endcase
    end
  end

  // pair swap and negotiation gate, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      swap_pairs_ab   <= 1'b0;
      swap_pairs_cd   <= 1'b0;
      an_start_enable <= 1'b0;
    end else begin
      swap_pairs_ab   <= crossed_q;
      swap_pairs_cd   <= crossed_q && copper_speed_1g;
      an_start_enable <= xstate_q == smcc_pkg::X_LOCK ||
                         (xstate_q == smcc_pkg::X_FORCED &&
                          crossed_q == xforce_q);
    end
  end

  // ---------------------------------------------------------------
  // indicator defaults per operating mode
  // ---------------------------------------------------------------
  logic [31:0] blink_q;
  logic        blink_ph_q;
  logic [2:0]  led_d;
  logic        cu_degraded;

  // divider producing the error blink phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_q    <= '0;
      blink_ph_q <= 1'b0;
    end else if (blink_q == BLINK_CYC - 1) begin
      blink_q    <= '0;
      blink_ph_q <= !blink_ph_q;
    end else begin
      blink_q    <= blink_q + 32'h1;
    end
  end

  assign cu_degraded = !copper_speed_1g || !copper_full_duplex;

  // indicator meaning selected by the working mode
  always_comb begin
    led_d = 3'h0;
    case (mode_q)
      smcc_pkg::MODE_RGMII_COPPER, smcc_pkg::MODE_SGMII_COPPER: begin
        led_d = {tx_activity || rx_activity,
                 link_up_copper && copper_speed_1g,
                 link_up_copper};
      end
      smcc_pkg::MODE_RGMII_1000X, smcc_pkg::MODE_RGMII_100FX: begin
        led_d = {rx_activity, tx_activity, link_up_fiber};
      end
      smcc_pkg::MODE_RGMII_SGMII: begin
        led_d = {tx_activity || rx_activity,
                 link_up_serial && serial_speed_1g,
                 link_up_serial};
      end
      smcc_pkg::MODE_COPPER_1000X, smcc_pkg::MODE_TX_100FX: begin
        led_d = {tx_activity || rx_activity, link_up_fiber,
                 link_up_copper &&
                 (!cu_degraded || blink_ph_q)};
      end
      default: led_d = 3'h0;
    endcase
  end

  // registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_out             <= 3'h0;
      mgmt_address        <= smcc_pkg::ADDR_RESET;
      operating_mode_code <= smcc_pkg::MODE_RESET;
    end else begin
      led_out             <= led_d;
      mgmt_address        <= addr_q;
      operating_mode_code <= mode_q;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_strap_hold_stable: assert property (
    strap_done_q |=> $stable(strap_q) && strap_done_q)
    else $error("latched straps changed");
  a_addr_level_map: assert property (
    capture |=> strap_q.addr == {$past(lvl_bin[1]), $past(lvl_bin[0])})
    else $error("address straps not mapped");
  a_level_binary: assert property (
    capture && pin_s2_q[7:5] == 3'h3 |=> strap_q.addr[1:0] == 2'h2)
    else $error("four-level mode 2 not 10");
  a_soft_reload: assert property (
    soft_rst |=> addr_q == strap_q.addr && mode_q == strap_q.mode)
    else $error("soft reset did not reload straps");
  a_forced_map: assert property (
    xstate_q == smcc_pkg::X_FORCED && $stable(xforce_q)
    |=> crossed_q == $past(xforce_q) ##1 swap_pairs_ab == $past(crossed_q))
    else $error("forced mapping not applied");
  a_an_after_resolve: assert property (
    an_start_enable |-> $past(xstate_q == smcc_pkg::X_LOCK ||
                              xstate_q == smcc_pkg::X_FORCED))
    else $error("negotiation before crossover resolved");
  a_cd_swap_gig: assert property (
    swap_pairs_cd |-> $past(crossed_q && copper_speed_1g))
    else $error("pairs C and D swapped outside gigabit");
  a_hunt_toggle: assert property (
    xstate_q == smcc_pkg::X_HUNT && slot_end && !xdis_q && !energy_detect
    |=> crossed_q != $past(crossed_q))
    else $error("hunt did not alternate mapping");
  a_led_copper_link: assert property (
    mode_q == smcc_pkg::MODE_RGMII_COPPER && link_up_copper
    && $stable(mode_q) |=> led_out[0])
    else $error("copper link indicator off");
  a_led_fiber_rx: assert property (
    mode_q == smcc_pkg::MODE_RGMII_1000X && $stable(mode_q)
    |=> led_out[2] == $past(rx_activity))
    else $error("receive indicator wrong");

  c_strap_capture: cover property (capture);
  c_hunt_lock: cover property (
    xstate_q == smcc_pkg::X_HUNT ##1 xstate_q == smcc_pkg::X_LOCK);
  c_forced_cross: cover property (
    xstate_q == smcc_pkg::X_FORCED && swap_pairs_ab);
  c_soft_reset: cover property (soft_rst);

endmodule

// ==== smcc_strap_board.sv ====
// board model: strap resistors on the strap-capable pins
`timescale 1ns/1ps
module smcc_strap_board (
  input  wire logic       aclk,
  input  wire logic       released,
  input  wire logic [1:0] lvl0,
  input  wire logic [1:0] lvl1,
  input  wire logic [2:0] mode,
  output logic [1:0][2:0] receive_data_pin_level,
  output logic [2:0]      operating_mode_strap,
  output logic            crossover_disable_strap,
  output logic            crossover_force_strap
);
  logic t_q = 1'b0;
  // -----------------------------------------------------------
  // resistor dividers, then functional traffic once released
  // -----------------------------------------------------------
  // four-level divider as a comparator thermometer
  function automatic logic [2:0] therm(input logic [1:0] l);
    return 3'(~(3'h7 << l));
  endfunction
  // pin toggles every cycle after sampling, so a late resample shows
  always_ff @(posedge aclk) t_q <= ~t_q;
  assign receive_data_pin_level[0] = released ? {3{t_q}} : therm(lvl0);
  assign receive_data_pin_level[1] = released ? {3{~t_q}} : therm(lvl1);
  assign operating_mode_strap = released ? {3{t_q}} : mode;
  assign crossover_disable_strap = released & t_q; // open resistor = 0
  assign crossover_force_strap   = released & ~t_q;
endmodule

// ==== test_strap_mode_and_crossover_config.sv ====
// testbench for the strap, mode and crossover loader
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module test_strap_mode_and_crossover_config;
  logic aclk = 0, aresetn = 0, released = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rdata, rd_data;
  logic [3:0]  wstrb = '0, mgmt_address;
  logic energy_detect = 0, link_up_copper = 0, copper_speed_1g = 0;
  logic copper_full_duplex = 0, link_up_fiber = 0, link_up_serial = 0;
  logic serial_speed_1g = 0, tx_activity = 0, rx_activity = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic swap_pairs_ab, swap_pairs_cd, an_start_enable;
  logic [1:0]  bresp, rresp, rd_resp, wr_resp;
  logic [2:0]  operating_mode_code, led_out, operating_mode_strap;
  logic [1:0][2:0] receive_data_pin_level;
  logic crossover_disable_strap, crossover_force_strap;
  int num_errors = 0, comparisons = 0;
  // -----------------------------------------------------------
  // clock, design and board
  // -----------------------------------------------------------
  always #2.5 aclk = ~aclk;
  smcc_top #(.SLOT_CYC(8), .BLINK_CYC(4)) dut_u (.aclk, .aresetn,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .receive_data_pin_level, .operating_mode_strap,
    .crossover_disable_strap, .crossover_force_strap, .energy_detect,
    .link_up_copper, .copper_speed_1g, .copper_full_duplex, .link_up_fiber,
    .link_up_serial, .serial_speed_1g, .tx_activity, .rx_activity,
    .mgmt_address, .operating_mode_code, .swap_pairs_ab, .swap_pairs_cd,
    .an_start_enable, .led_out);
  // data 0 at level 2, data 1 at level 1, mode 100, crossover straps open
  smcc_strap_board board_u (.aclk, .released, .lvl0(2'h2), .lvl1(2'h1),
    .mode(smcc_pkg::MODE_COPPER_1000X), .receive_data_pin_level,
    .operating_mode_strap, .crossover_disable_strap,
    .crossover_force_strap);
  // -----------------------------------------------------------
  // bus tasks
  // -----------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    bit pa = 1, pw = 1, pb = 1;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (pb) begin
      @(posedge aclk);
      if (pa && awready) begin awvalid <= 1'b0; pa = 0; end
      if (pw && wready) begin wvalid <= 1'b0; pw = 0; end
      if (bvalid) begin bready <= 1'b0; pb = 0; wr_resp = bresp; end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    bit pa = 1, pr = 1;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (pr) begin
      @(posedge aclk);
      if (pa && arready) begin arvalid <= 1'b0; pa = 0; end
      if (rvalid) begin rready <= 1'b0; pr = 0; rd_data = rdata;
        rd_resp = rresp; end
    end
  endtask
  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic t_straps();
    rd(smcc_pkg::OFS_STRAP);
    `CHK(rd_data, 32'h0000_00d0)
    `CHK(rd_resp, smcc_pkg::RESP_OKAY)
    `CHK(mgmt_address, 4'h6)
    `CHK(operating_mode_code, smcc_pkg::MODE_COPPER_1000X)
    rd(smcc_pkg::OFS_STATUS);
    `CHK(rd_data[0], 1'b1)
    released <= 1'b1;
    tick(10);
    rd(smcc_pkg::OFS_STRAP);
    `CHK(rd_data, 32'h0000_00d0)
    `CHK(mgmt_address, 4'h6)
  endtask
  task automatic led_case(input logic [2:0] m, input logic [2:0] e);
    wr(smcc_pkg::OFS_CFG, {25'h0, m, 4'ha}, 4'h1);
    `CHK(wr_resp, smcc_pkg::RESP_OKAY)
    tick(3);
    `CHK(mgmt_address, 4'ha)
    `CHK(operating_mode_code, m)
    `CHK(led_out, e)
  endtask
  task automatic t_leds();
    int n = 0;
    link_up_copper <= 1'b1; copper_full_duplex <= 1'b1;
    link_up_fiber <= 1'b1; tx_activity <= 1'b1; link_up_serial <= 1'b1;
    led_case(smcc_pkg::MODE_RGMII_COPPER, 3'b101);
    led_case(smcc_pkg::MODE_RGMII_1000X, 3'b011);
    led_case(smcc_pkg::MODE_RGMII_100FX, 3'b011);
    led_case(smcc_pkg::MODE_RGMII_SGMII, 3'b101);
    copper_speed_1g <= 1'b1;
    led_case(smcc_pkg::MODE_COPPER_1000X, 3'b111);
    copper_speed_1g <= 1'b0;
    tick(3);
    // link at 100M: error blink, half period of four cycles
    repeat (8) begin tick(1); n += int'(led_out[0] === 1'b1); end
    `CHK(n, 4)
    // remaining modes: 110 as 000, 111 dark, 101 as 100
    led_case(smcc_pkg::MODE_SGMII_COPPER, 3'b101);
    led_case(smcc_pkg::MODE_BSCAN, 3'b000);
    copper_speed_1g <= 1'b1;
    led_case(smcc_pkg::MODE_TX_100FX, 3'b111);
  endtask
  task automatic t_soft();
    wr(smcc_pkg::OFS_CFG, 32'h8000_0000, 4'h8);
    tick(4);
    `CHK(mgmt_address, 4'h6)
    `CHK(operating_mode_code, smcc_pkg::MODE_COPPER_1000X)
  endtask
  task automatic t_cross();
    int n = 0;
    logic s;
    copper_speed_1g <= 1'b1;
    wr(smcc_pkg::OFS_PHYCTL, 32'h60, 4'h1);
    tick(4);
    `CHK(swap_pairs_ab, 1'b1)
    `CHK(swap_pairs_cd, 1'b1)
    wr(smcc_pkg::OFS_PHYCTL, 32'h40, 4'h1);
    tick(4);
    `CHK(swap_pairs_ab, 1'b0)
    // 100M, no energy, no link: auto crossover hunts
    copper_speed_1g <= 1'b0; link_up_copper <= 1'b0;
    wr(smcc_pkg::OFS_PHYCTL, 32'h0, 4'h1);
    tick(3);
    `CHK(an_start_enable, 1'b0)
    s = swap_pairs_ab;
    repeat (20) begin tick(1); n += int'(swap_pairs_ab !== s);
      s = swap_pairs_ab; end
    `CHK(n > 0, 1'b1)
    energy_detect <= 1'b1;
    tick(4);
    s = swap_pairs_ab;
    tick(20);
    `CHK(swap_pairs_ab, s)
    `CHK(swap_pairs_cd, 1'b0)
    `CHK(an_start_enable, 1'b1)
  endtask
  task automatic t_unmapped();
    wr(8'h20, 32'hffff_ffff, 4'hf);
    `CHK(wr_resp, smcc_pkg::RESP_SLVERR)
    rd(8'h20);
    `CHK(rd_resp, smcc_pkg::RESP_SLVERR)
    `CHK(rd_data, 32'h0)
  endtask
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence: reset held twenty cycles, then straps settle
  initial begin
    tick(20);
    aresetn <= 1'b1;
    tick(30);
    t_straps(); t_leds(); t_soft(); t_cross(); t_unmapped();
    print_verdict();
  end
  // watchdog against a hung handshake
  initial begin
    tick(4000);
    num_errors++;
    print_verdict();
  end
endmodule
